// *** logic/osc_source_ctrl.sv ***
// Oscillator source control: precision oscillator trim with spread spectrum,
// low-power oscillator auto-enable, external oscillator configuration, and
// an Avalon-MM register slave with a level interrupt.
// Assumes all inputs are synchronous to mclk and that prec_osc_tick pulses
// once for every period of the precision oscillator.
//
// The register addresses and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ns
`include "osc_params.svh"
module osc_source_ctrl #(
  parameter int STALL_CYC = `OSC_STALL_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Interrupt
  output logic irq,
  // Precision oscillator
  input wire logic [6:0] factory_trim,
  input wire logic prec_osc_tick,
  output logic [6:0] precision_osc_trim,
  // Low-power oscillator
  input wire logic lpo_periph_req,
  output logic lpo_enable,
  // External oscillator analog front end
  input wire logic osc_pin_two_in,
  output logic osc_pin_one_amp_en,
  output logic osc_pin_two_amp_en,
  output logic [2:0] ext_osc_freq_code,
  output logic ext_rc_mode,
  output logic ext_cap_mode,
  // Clock routing
  output logic [2:0] system_clock_sel,
  output logic ext_clk_en,
  output logic ext_periph_clk_en
);
  import osc_pkg::*;

  // Register state
  logic sse_r, sse_nxt;
  osc_src_e sel_r, sel_nxt;
  logic [6:0] trim_r, trim_nxt;
  logic trim_loaded_r, trim_loaded_nxt;
  logic ext_en_r, ext_en_nxt;
  osc_code_t ext_mode_r, ext_mode_nxt;
  osc_code_t ext_freq_r, ext_freq_nxt;
  logic [1:0] irq_stat_r, irq_stat_nxt;
  logic [1:0] irq_mask_r, irq_mask_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  // Spread spectrum state
  osc_tri_e tri_r, tri_nxt;
  logic [2:0] step_r, step_nxt;
  logic [4:0] tick_cnt_r, tick_cnt_nxt;
  logic [6:0] trim_out_r, trim_out_nxt;
  // Derived
  logic wr_take, rd_take, ext_restart, det_valid, det_rise, det_lost, det_clk_en;
  logic mode_known, mode_div2, mode_cmos;
  logic [6:0] ss_offset;

  function automatic logic [31:0] osc_word(input logic [31:0] v);
    osc_word = v;
  endfunction

  // Register byte offset match inside a bank
  function automatic logic osc_hit(input logic [4:0] addr, input logic bank,
                                   input logic [3:0] off);
    osc_hit = (addr[4] == bank) && (addr[3:0] == off);
  endfunction

  // Bus handshake: the request waits one cycle, then completes
  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
  assign wr_take = avs_write && ack_r;
  assign rd_take = avs_read && ack_r;
  assign avs_readdata = rdata_r;

  always_comb begin
    ack_nxt = (avs_read || avs_write) && !ack_r;
    rdata_nxt = rdata_r;
    if (avs_read && !ack_r) begin
      rdata_nxt = 32'h0000_0000;
      if (osc_hit(avs_address, 1'b0, `OSC_OFF_CTRL)) begin
        rdata_nxt[`OSC_CTRL_SSE_BIT] = sse_r;
        rdata_nxt[`OSC_CTRL_SEL_LSB +: 3] = sel_r;
      end else if (osc_hit(avs_address, 1'b0, `OSC_OFF_TRIM)) begin
        rdata_nxt[6:0] = trim_r;
      end else if (osc_hit(avs_address, 1'b0, `OSC_OFF_EXT)) begin
        rdata_nxt[`OSC_EXT_FREQ_LSB +: 3] = ext_freq_r;
        rdata_nxt[`OSC_EXT_MODE_LSB +: 3] = ext_mode_r;
        rdata_nxt[`OSC_EXT_EN_BIT] = ext_en_r;
      end else if (osc_hit(avs_address, 1'b0, `OSC_OFF_STAT)) begin
        rdata_nxt[`OSC_STAT_VALID_BIT] = det_valid;
        rdata_nxt[`OSC_STAT_LPO_BIT] = lpo_enable;
        rdata_nxt[`OSC_STAT_SS_BIT] = (step_r != 3'h0);
        rdata_nxt[`OSC_STAT_STEP_LSB +: 3] = step_r;
      end else if (osc_hit(avs_address, 1'b1, `OSC_OFF_IRQ_STAT)) begin
        rdata_nxt[1:0] = irq_stat_r;
      end else if (osc_hit(avs_address, 1'b1, `OSC_OFF_IRQ_MASK)) begin
        rdata_nxt[1:0] = irq_mask_r;
      end
    end
  end

  // Control registers
  always_comb begin
    sse_nxt = sse_r;
    sel_nxt = sel_r;
    trim_nxt = trim_r;
    trim_loaded_nxt = 1'b1;
    ext_en_nxt = ext_en_r;
    ext_mode_nxt = ext_mode_r;
    ext_freq_nxt = ext_freq_r;
    irq_mask_nxt = irq_mask_r;
    // Factory value is taken just after reset release, not under reset
    if (!trim_loaded_r) begin
      trim_nxt = factory_trim;
    end
    if (wr_take) begin
      if (osc_hit(avs_address, 1'b0, `OSC_OFF_CTRL)) begin
        sse_nxt = avs_writedata[`OSC_CTRL_SSE_BIT];
        sel_nxt = osc_src_e'(avs_writedata[`OSC_CTRL_SEL_LSB +: 3]);
      end else if (osc_hit(avs_address, 1'b0, `OSC_OFF_TRIM)) begin
        trim_nxt = avs_writedata[6:0];
      end else if (osc_hit(avs_address, 1'b0, `OSC_OFF_EXT)) begin
        ext_freq_nxt = avs_writedata[`OSC_EXT_FREQ_LSB +: 3];
        ext_mode_nxt = avs_writedata[`OSC_EXT_MODE_LSB +: 3];
        ext_en_nxt = avs_writedata[`OSC_EXT_EN_BIT];
      end else if (osc_hit(avs_address, 1'b1, `OSC_OFF_IRQ_MASK)) begin
        irq_mask_nxt = avs_writedata[1:0];
      end
    end
  end

  // Any write that turns enable on or changes mode restarts the valid detector
  assign ext_restart = (ext_en_nxt && !ext_en_r) || (ext_mode_nxt != ext_mode_r);

  // Sticky status: a read clears only the bits it returned, so an event
  // landing between capture and completion is not lost; a new event wins
  always_comb begin
    irq_stat_nxt = irq_stat_r;
    if (rd_take && osc_hit(avs_address, 1'b1, `OSC_OFF_IRQ_STAT)) begin
      irq_stat_nxt = irq_stat_r & ~rdata_r[1:0];
    end
    if (det_rise) begin
      irq_stat_nxt[`OSC_IRQ_VALID_BIT] = 1'b1;
    end
    if (det_lost) begin
      irq_stat_nxt[`OSC_IRQ_LOST_BIT] = 1'b1;
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      sse_r <= 1'b0;
      sel_r <= osc_src_e'(`OSC_SEL_RST);
      trim_r <= 7'h00;
      trim_loaded_r <= 1'b0;
      ext_en_r <= 1'(`OSC_EXT_RST >> `OSC_EXT_EN_BIT);
      ext_mode_r <= 3'h0;
      ext_freq_r <= 3'h0;
      irq_stat_r <= 2'h0;
      irq_mask_r <= `OSC_MASK_RST;
    end else begin
      ack_r <= ack_nxt;
      rdata_r <= osc_word(rdata_nxt);
      sse_r <= sse_nxt;
      sel_r <= sel_nxt;
      trim_r <= trim_nxt;
      trim_loaded_r <= trim_loaded_nxt;
      ext_en_r <= ext_en_nxt;
      ext_mode_r <= ext_mode_nxt;
      ext_freq_r <= ext_freq_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
    end
  end

  // Spread spectrum triangle: 6 steps down then 6 up, each step 32 oscillator
  // periods, so one full triangle spans 384 periods.
  // The offset is only ever subtracted, so the frequency never rises.
  assign ss_offset = 7'(step_r) * `OSC_SS_TRIM_STEP;

  always_comb begin
    tri_nxt = tri_r;
    step_nxt = step_r;
    tick_cnt_nxt = tick_cnt_r;
    trim_out_nxt = trim_out_r;
    if (prec_osc_tick) begin
      if (tick_cnt_r == 5'(`OSC_SS_TICKS - 1)) begin
        tick_cnt_nxt = 5'h00;
        // Steps change only on a boundary, so stopping never jumps mid-step
        unique case (tri_r)
          OSC_TRI_DOWN: begin
            if (!sse_r) begin
              tri_nxt = OSC_TRI_UP;
            end else if (step_r == 3'(`OSC_SS_STEPS - 1)) begin
              step_nxt = step_r + 3'h1;
              tri_nxt = OSC_TRI_UP;
            end else begin
              step_nxt = step_r + 3'h1;
            end
          end
          OSC_TRI_UP: begin
            if (step_r == 3'h0) begin
              tri_nxt = OSC_TRI_DOWN;
            end else if (step_r == 3'h1) begin
              step_nxt = 3'h0;
              tri_nxt = OSC_TRI_DOWN;
            end else begin
              step_nxt = step_r - 3'h1;
            end
          end
        endcase
      end else if (sse_r || step_r != 3'h0) begin
        tick_cnt_nxt = tick_cnt_r + 5'h01;
      end else begin
        tick_cnt_nxt = 5'h00;
      end
    end
    // Output trim is registered every cycle as trim_r less the step offset, floored at zero
    if (trim_r < ss_offset) begin
      trim_out_nxt = 7'h00;
    end else begin
      trim_out_nxt = trim_r - ss_offset;
    end
  end

  assign precision_osc_trim = trim_out_r;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tri_r <= OSC_TRI_DOWN;
      step_r <= 3'h0;
      tick_cnt_r <= 5'h00;
      trim_out_r <= 7'h00;
    end else begin
      tri_r <= tri_nxt;
      step_r <= step_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      trim_out_r <= trim_out_nxt;
    end
  end

  // Low-power oscillator runs only while someone needs it
  assign lpo_enable = (sel_r == OSC_SRC_LPO) || (sel_r == OSC_SRC_LPO_DIV8)
                      || lpo_periph_req;

  // External oscillator mode decode; reserved codes leave the circuit idle
  assign mode_known = (ext_mode_r <= OSC_EXT_CAP);
  assign mode_cmos = (ext_mode_r == OSC_EXT_CMOS);
  assign mode_div2 = (ext_mode_r == OSC_EXT_XTAL_DIV2) || (ext_mode_r == OSC_EXT_RC)
                     || (ext_mode_r == OSC_EXT_CAP);

  // Pin one is only driven by the amplifier in the two crystal modes
  assign osc_pin_one_amp_en = ext_en_r && ((ext_mode_r == OSC_EXT_XTAL)
                              || (ext_mode_r == OSC_EXT_XTAL_DIV2));
  assign osc_pin_two_amp_en = ext_en_r && mode_known && !mode_cmos;
  assign ext_rc_mode = ext_en_r && (ext_mode_r == OSC_EXT_RC);
  assign ext_cap_mode = ext_en_r && (ext_mode_r == OSC_EXT_CAP);
  assign ext_osc_freq_code = ext_freq_r;

  osc_ext_cond #(
    .STALL_CYC(STALL_CYC)
  ) u_ext_cond (
    .mclk(mclk),
    .rst(rst),
    .run(ext_en_r && mode_known),
    .restart(ext_restart),
    .use_div2(mode_div2),
    .cmos_in_mode(mode_cmos),
    .pin_two_in(osc_pin_two_in),
    .clk_en(det_clk_en),
    .valid(det_valid),
    .valid_rise(det_rise),
    .valid_lost(det_lost)
  );

  // External clock goes to the system clock mux and to peripherals
  assign system_clock_sel = sel_r;
  assign ext_clk_en = det_clk_en && (sel_r == OSC_SRC_EXT);
  assign ext_periph_clk_en = det_clk_en;
endmodule

// *** logic/osc_params.svh ***
// Offsets, field positions, reset values and timing counts of the oscillator source control.
// Assumes the 100 MHz mclk and a byte-addressed Avalon-MM register window.
`ifndef OSC_PARAMS_SVH
`define OSC_PARAMS_SVH

`define OSC_CLK_PERIOD_NS 10
// Register byte offsets
`define OSC_OFF_CTRL 4'h0
`define OSC_OFF_TRIM 4'h4
`define OSC_OFF_EXT 4'h8
`define OSC_OFF_STAT 4'hC
// Second bank selected by address bit 4
`define OSC_OFF_IRQ_STAT 4'h0
`define OSC_OFF_IRQ_MASK 4'h4
// Control register fields
`define OSC_CTRL_SSE_BIT 0
`define OSC_CTRL_SEL_LSB 4
// External control register fields
`define OSC_EXT_FREQ_LSB 0
`define OSC_EXT_MODE_LSB 4
`define OSC_EXT_EN_BIT 7
// Status register fields
`define OSC_STAT_VALID_BIT 0
`define OSC_STAT_LPO_BIT 1
`define OSC_STAT_SS_BIT 2
`define OSC_STAT_STEP_LSB 8
// Interrupt bits
`define OSC_IRQ_VALID_BIT 0
`define OSC_IRQ_LOST_BIT 1
// Reset values
`define OSC_SEL_RST 3'h4
`define OSC_EXT_RST 8'h00
`define OSC_MASK_RST 2'h0
// Spread spectrum: 384 oscillator cycles per triangle, 6 steps down and 6 back
`define OSC_SS_DIV 384
`define OSC_SS_STEPS 6
`define OSC_SS_TICKS (`OSC_SS_DIV / (2 * `OSC_SS_STEPS))
`define OSC_SS_TRIM_STEP 7'h01
// Valid detector: edges needed, and the longest gap between pin edges
`define OSC_VALID_EDGES 64
`define OSC_STALL_NS 100000
`define OSC_STALL_CYC (`OSC_STALL_NS / `OSC_CLK_PERIOD_NS)

`endif

// *** logic/osc_pkg.sv ***
// Types shared by the oscillator source control files.
// Assumes osc_params.svh for all numeric constants.
package osc_pkg;
  typedef logic [2:0] osc_code_t;
  typedef enum logic [2:0] {
    OSC_SRC_HFO = 3'h0,
    OSC_SRC_EXT = 3'h1,
    OSC_SRC_LPO_DIV8 = 3'h2,
    OSC_SRC_RTC = 3'h3,
    OSC_SRC_LPO = 3'h4
  } osc_src_e;
  typedef enum logic [2:0] {
    OSC_EXT_CMOS = 3'h0,
    OSC_EXT_XTAL = 3'h1,
    OSC_EXT_XTAL_DIV2 = 3'h2,
    OSC_EXT_RC = 3'h3,
    OSC_EXT_CAP = 3'h4
  } osc_ext_mode_e;
  typedef enum logic [2:0] {
    OSC_DET_OFF = 3'b001,
    OSC_DET_COUNT = 3'b010,
    OSC_DET_VALID = 3'b100
  } osc_det_e;
  typedef enum logic [1:0] {
    OSC_TRI_DOWN = 2'b01,
    OSC_TRI_UP = 2'b10
  } osc_tri_e;
endpackage

// *** logic/osc_ext_cond.sv ***
// External oscillator conditioning: edge detection, optional divide by two,
// and the oscillation-valid detector.
// Assumes pin_two_in is already a digital level synchronous to mclk.
`timescale 1ns/1ns
`include "osc_params.svh"
module osc_ext_cond #(
  parameter int STALL_CYC = `OSC_STALL_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Control
  input wire logic run,
  input wire logic restart,
  input wire logic use_div2,
  input wire logic cmos_in_mode,
  // Pin level
  input wire logic pin_two_in,
  // Results
  output logic clk_en,
  output logic valid,
  output logic valid_rise,
  output logic valid_lost
);
  import osc_pkg::*;

  osc_det_e det_r, det_nxt;
  logic pin_r, pin_nxt;
  logic half_r, half_nxt;
  logic [6:0] edge_cnt_r, edge_cnt_nxt;
  logic [16:0] gap_r, gap_nxt;
  logic rise;

  always_comb begin
    pin_nxt = pin_two_in;
    rise = pin_two_in && !pin_r;
    half_nxt = half_r;
    clk_en = 1'b0;
    edge_cnt_nxt = edge_cnt_r;
    gap_nxt = gap_r;
    det_nxt = det_r;
    valid_rise = 1'b0;
    valid_lost = 1'b0;
    if (run && rise) begin
      half_nxt = !half_r;
      clk_en = use_div2 ? half_r : 1'b1;
    end
    unique case (det_r)
      OSC_DET_OFF: begin
        edge_cnt_nxt = '0;
        gap_nxt = '0;
        if (run && !cmos_in_mode) begin
          det_nxt = OSC_DET_COUNT;
        end
      end
      OSC_DET_COUNT: begin
        gap_nxt = rise ? 17'h0_0000 : gap_r + 17'h0_0001;
        if (rise) begin
          edge_cnt_nxt = edge_cnt_r + 7'h01;
        end
        if (gap_r >= 17'(STALL_CYC)) begin
          edge_cnt_nxt = '0;
          gap_nxt = '0;
        end else if (edge_cnt_r == 7'(`OSC_VALID_EDGES)) begin
          det_nxt = OSC_DET_VALID;
          valid_rise = 1'b1;
        end
      end
      OSC_DET_VALID: begin
        gap_nxt = rise ? 17'h0_0000 : gap_r + 17'h0_0001;
        if (gap_r >= 17'(STALL_CYC)) begin
          det_nxt = OSC_DET_COUNT;
          edge_cnt_nxt = '0;
          gap_nxt = '0;
          valid_lost = 1'b1;
        end
      end
    endcase
    // A new configuration always starts detection from scratch
    if (!run || cmos_in_mode || restart) begin
      det_nxt = OSC_DET_OFF;
      half_nxt = 1'b0;
    end
  end

  assign valid = (det_r == OSC_DET_VALID);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      det_r <= OSC_DET_OFF;
      pin_r <= 1'b0;
      half_r <= 1'b0;
      edge_cnt_r <= '0;
      gap_r <= '0;
    end else begin
      det_r <= det_nxt;
      pin_r <= pin_nxt;
      half_r <= half_nxt;
      edge_cnt_r <= edge_cnt_nxt;
      gap_r <= gap_nxt;
    end
  end
endmodule

// *** tb/osc_source_ctrl_properties.sv ***
// Port-level checks on the oscillator source control block.
// Assumes a single mclk domain with rst asynchronous and active high.
`timescale 1ns/1ns
module osc_ctrl_checker #(
  parameter int STALL_CYC = 200
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register bus
  input wire logic avs_write,
  input wire logic avs_read,
  input wire logic avs_waitrequest,
  // Oscillator controls
  input wire logic [6:0] precision_osc_trim,
  input wire logic lpo_periph_req,
  input wire logic lpo_enable,
  input wire logic osc_pin_one_amp_en,
  input wire logic osc_pin_two_amp_en,
  input wire logic [2:0] ext_osc_freq_code,
  input wire logic ext_rc_mode,
  input wire logic ext_cap_mode,
  input wire logic [2:0] system_clock_sel,
  input wire logic ext_clk_en,
  input wire logic ext_periph_clk_en
);
  logic [2:0] age_r;
  logic [2:0] age_nxt;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Trim may jump on its reset load and after a write, so step checks wait a few cycles and skip the two cycles after a write
  always_comb begin
    age_nxt = (age_r == 3'h7) ? age_r : age_r + 3'h1;
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      age_r <= 3'h0;
    end else begin
      age_r <= age_nxt;
    end
  end
  chk_lpo_auto: assert property (lpo_enable == (system_clock_sel == 3'h4 ||
    system_clock_sel == 3'h2 || lpo_periph_req)) else $error("lpo enable wrong");
  chk_reset_sel: assert property ($fell(rst) |-> system_clock_sel == 3'h4 && lpo_enable)
    else $error("source after reset wrong");
  chk_pin_one_free: assert property (ext_rc_mode || ext_cap_mode |->
    !osc_pin_one_amp_en && osc_pin_two_amp_en) else $error("pin one used");
  chk_sys_route: assert property (ext_clk_en |-> system_clock_sel == 3'h1 && ext_periph_clk_en)
    else $error("ext clock routing wrong");
  chk_code_hold: assert property ($changed(ext_osc_freq_code) |-> $past(avs_write))
    else $error("freq code moved without write");
  chk_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=>
    !avs_waitrequest) else $error("bus answer late");
  chk_trim_step: assert property (age_r == 3'h7 && !$past(avs_write) && !$past(avs_write, 2)
    |-> precision_osc_trim - $past(precision_osc_trim) inside {7'h00, 7'h01, 7'h7f})
    else $error("trim step too large");
  chk_amp_pair: assert property (!osc_pin_two_amp_en |->
    !osc_pin_one_amp_en && !ext_rc_mode && !ext_cap_mode) else $error("amp enables mixed");
endmodule

bind osc_source_ctrl osc_ctrl_checker #(.STALL_CYC(STALL_CYC)) i_chk (
  .mclk(mclk), .rst(rst), .avs_write(avs_write), .avs_read(avs_read),
  .avs_waitrequest(avs_waitrequest), .precision_osc_trim(precision_osc_trim),
  .lpo_periph_req(lpo_periph_req), .lpo_enable(lpo_enable),
  .osc_pin_one_amp_en(osc_pin_one_amp_en), .osc_pin_two_amp_en(osc_pin_two_amp_en),
  .ext_osc_freq_code(ext_osc_freq_code), .ext_rc_mode(ext_rc_mode),
  .ext_cap_mode(ext_cap_mode), .system_clock_sel(system_clock_sel),
  .ext_clk_en(ext_clk_en), .ext_periph_clk_en(ext_periph_clk_en)
);

// *** tb/osc_net_model.sv ***
// Behavioural timing network on oscillator pin two.
// Assumes the bench sets the half period in mclk cycles.
`timescale 1ns/1ns
module osc_net_model (
  // Clock
  input wire logic mclk,
  // Drive from device and bench
  input wire logic amp_en,
  input wire logic cmos_drive,
  input wire logic run,
  input wire logic [7:0] half,
  // Pin level
  output logic pin_two
);
  logic [7:0] cnt = 8'h00;
  initial pin_two = 1'b1;
  // Swings only while driven; otherwise the pull-up holds the pin high
  always @(posedge mclk) begin
    if (run && (amp_en || cmos_drive)) begin
      cnt <= (cnt + 8'h01 >= half) ? 8'h00 : cnt + 8'h01;
      if (cnt + 8'h01 >= half) begin
        pin_two <= !pin_two;
      end
    end else begin
      cnt <= 8'h00;
      pin_two <= 1'b1;
    end
  end
endmodule

// *** tb/osc_source_ctrl_tb_top.sv ***
// Self-checking bench for the oscillator source control block.
// Assumes a 100 MHz mclk and the pin two network model.
`timescale 1ns/1ns
module osc_source_ctrl_tb_top;
  localparam logic [6:0] FTRIM = 7'h35;
  logic mclk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, lpo_periph_req = 1'b0;
  logic run = 1'b0, cmos_drive = 1'b0, pin_d = 1'b1, pin_two;
  logic [4:0] avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic avs_waitrequest, irq, lpo_enable, pin1_en, pin2_en, rc_m, cap_m, clk_en, pclk_en;
  logic [6:0] trim_out;
  logic [2:0] code, sel;
  logic [7:0] half = 8'h04;
  int n_fail = 0, num_checks = 0, n_edge = 0, n_pulse = 0, n_sys = 0;
  int lo, hi, cnt6, e0, p0, s0;

  osc_source_ctrl #(.STALL_CYC(200)) i_dut (
    .mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .factory_trim(FTRIM), .prec_osc_tick(1'b1),
    .precision_osc_trim(trim_out), .lpo_periph_req(lpo_periph_req), .lpo_enable(lpo_enable),
    .osc_pin_two_in(pin_two), .osc_pin_one_amp_en(pin1_en), .osc_pin_two_amp_en(pin2_en),
    .ext_osc_freq_code(code), .ext_rc_mode(rc_m), .ext_cap_mode(cap_m),
    .system_clock_sel(sel), .ext_clk_en(clk_en), .ext_periph_clk_en(pclk_en)
  );
  osc_net_model i_net (
    .mclk(mclk), .amp_en(pin2_en), .cmos_drive(cmos_drive), .run(run), .half(half),
    .pin_two(pin_two)
  );

  always #5 mclk = !mclk;
  always @(posedge mclk) begin
    pin_d <= pin_two;
    if (pin_two && !pin_d) n_edge <= n_edge + 1;
    if (pclk_en === 1'b1) n_pulse <= n_pulse + 1;
    if (clk_en === 1'b1) n_sys <= n_sys + 1;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Holds the request until waitrequest is sampled low at an edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      n_fail++;
      complete_run();
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    @(negedge mclk);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] exp, input logic [31:0] m = '1);
    bus(1'b0, a, 32'h0);
    check(q & m, exp);
  endtask

  task automatic poll_valid();
    int k;
    k = 0;
    do begin
      bus(1'b0, 5'h0C, 32'h0);
      k++;
    end while (q[0] !== 1'b1 && k < 1000);
    check(q[0], 1'b1);
    if (q[0] !== 1'b1) complete_run();
  endtask

  // Compares clock enables with pin edges seen over a fixed span
  task automatic window(input int div, input int sys);
    e0 = n_edge;
    p0 = n_pulse;
    s0 = n_sys;
    repeat (400) @(posedge mclk);
    check(((n_pulse - p0) * div - (n_edge - e0)) inside {[-2 * div:2 * div]}, 1'b1);
    check(n_sys - s0, (sys != 0) ? n_pulse - p0 : 0);
  endtask

  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(negedge mclk);
    check(sel, 3'h4);
    rd(5'h00, 32'h40);
    rd(5'h04, 32'h35);
    check(trim_out, FTRIM);
    rd(5'h18, 32'h0);
    wr(5'h1C, 32'hFFFF_FFFF);
    rd(5'h1C, 32'h0);
    $display("reset test done");
    wr(5'h00, 32'h0);
    check(lpo_enable, 1'b0);
    @(posedge mclk);
    lpo_periph_req <= 1'b1;
    @(negedge mclk);
    check(lpo_enable, 1'b1);
    @(posedge mclk);
    lpo_periph_req <= 1'b0;
    wr(5'h00, 32'h20);
    rd(5'h0C, 32'h2, 32'h2);
    $display("low-power test done");
    wr(5'h00, 32'h41);
    lo = 127;
    hi = 0;
    cnt6 = 0;
    repeat (768) begin
      @(posedge mclk);
      if (trim_out < lo) lo = trim_out;
      if (trim_out > hi) hi = trim_out;
      if (trim_out === FTRIM - 7'h06) cnt6++;
    end
    check(lo, FTRIM - 7'h06);
    check(hi, FTRIM);
    check(cnt6, 64);
    wr(5'h00, 32'h40);
    repeat (260) @(posedge mclk);
    check(trim_out, FTRIM);
    rd(5'h0C, 32'h0, 32'h4);
    $display("spread test done");
    wr(5'h14, 32'h2);
    wr(5'h08, 32'h97);
    check({pin1_en, pin2_en, code}, 5'h1F);
    rd(5'h0C, 32'h0, 32'h1);
    @(posedge mclk);
    run <= 1'b1;
    poll_valid();
    check(irq, 1'b0);
    wr(5'h14, 32'h3);
    @(negedge mclk);
    check(irq, 1'b1);
    rd(5'h10, 32'h1);
    repeat (2) @(negedge mclk);
    check(irq, 1'b0);
    wr(5'h00, 32'h10);
    window(1, 1);
    @(posedge mclk);
    run <= 1'b0;
    repeat (260) @(posedge mclk);
    rd(5'h0C, 32'h0, 32'h1);
    rd(5'h10, 32'h2);
    wr(5'h00, 32'h40);
    @(posedge mclk);
    run <= 1'b1;
    $display("crystal test done");
    for (int m = 0; m < 5; m++) begin
      @(posedge mclk);
      half <= 8'(4 + m);
      cmos_drive <= (m == 0);
      wr(5'h08, 32'h80 | (m << 4) | m);
      rd(5'h0C, 32'h0, 32'h1);
      check({pin1_en, rc_m, cap_m}, {m == 1 || m == 2, m == 3, m == 4});
      repeat (1500) @(posedge mclk);
      window((m >= 2) ? 2 : 1, 0);
      rd(5'h0C, (m != 0), 32'h1);
    end
    @(posedge mclk);
    cmos_drive <= 1'b0;
    wr(5'h08, 32'h14);
    check({pin1_en, pin2_en}, 2'b00);
    rd(5'h0C, 32'h0, 32'h1);
    $display("mode test done");
    complete_run();
  end
endmodule
